// ---- design/touch_adc_serial_port.sv ----
// Serial control, conversion sequencing and result shifter of the touch converter
`timescale 1ns/1ps
module touch_adc_serial_port #(
   parameter int RESULT_W = 12
) (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      chip_sel_n,
   input  wire logic                      serial_conv_clock,
   input  wire logic                      serial_din,
   input  wire logic                      cmp_above,
   input  wire logic                      pen_touched,
   output touch_adc_pkg::serial_out_t     serial_out,
   output logic                           pen_touch_irq_n,
   output logic                           pen_touch_irq_n_oe,
   output logic                           track_hold_acquire,
   output logic [RESULT_W-1:0]            sar_code,
   output touch_adc_pkg::conv_ctrl_t      conv_ctrl,
   output logic                           ctrl_valid
);
   import touch_adc_pkg::*;

   typedef struct packed {
      logic                cs_s1;
      logic                cs_s2;
      logic                ck_s1;
      logic                ck_s2;
      logic                ck_s3;
      logic                din_s1;
      logic                din_s2;
      logic                cmp_s1;
      logic                cmp_s2;
      logic                pen_s1;
      logic                pen_s2;
      phase_t              phase;
      logic [4:0]          fcnt;
      logic [2:0]          rcnt;
      logic [6:0]          ctrl;
      logic [6:0]          shift;
      logic                track;
      logic                busy;
      logic                dout;
      logic [RESULT_W-1:0] trial;
      logic [RESULT_W-1:0] result;
      logic [RESULT_W-1:0] dac;
      logic                valid;
   } state_t;

   localparam logic [RESULT_W-1:0] MSB_BIT = {1'b1, {(RESULT_W-1){1'b0}}};

   state_t st_ff;
   state_t nxt_st;
   logic   ck_rise;
   logic   ck_fall;

   // Checks below sample on the system clock and rest during reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Edges of the serial clock, seen through the synchroniser
   assign ck_rise = st_ff.ck_s2 & ~st_ff.ck_s3;
   assign ck_fall = ~st_ff.ck_s2 & st_ff.ck_s3;

   // Sequencer: start detect, control capture, acquisition, approximation
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.cs_s1  = chip_sel_n;
      nxt_st.cs_s2  = st_ff.cs_s1;
      nxt_st.ck_s1  = serial_conv_clock;
      nxt_st.ck_s2  = st_ff.ck_s1;
      nxt_st.ck_s3  = st_ff.ck_s2;
      nxt_st.din_s1 = serial_din;
      nxt_st.din_s2 = st_ff.din_s1;
      nxt_st.cmp_s1 = cmp_above;
      nxt_st.cmp_s2 = st_ff.cmp_s1;
      nxt_st.pen_s1 = pen_touched;
      nxt_st.pen_s2 = st_ff.pen_s1;
      if (st_ff.cs_s2) begin
         // Deselected: clock and data ignored, partial word dropped
         nxt_st.phase = PH_IDLE;
         nxt_st.fcnt  = RST_FCNT;
         nxt_st.rcnt  = RST_RCNT;
         nxt_st.track = 1'b0;
         nxt_st.busy  = 1'b0;
         nxt_st.dout  = 1'b0;
      end else begin
         case (st_ff.phase)
            PH_IDLE: begin
               // A one on the input at a rising edge is the start bit
               if (ck_rise && st_ff.din_s2) begin
                  nxt_st.phase = PH_CTRL;
                  nxt_st.fcnt  = RST_FCNT;
                  nxt_st.rcnt  = RST_RCNT;
               end
               if (ck_fall) begin
                  nxt_st.dout = 1'b0;
               end
            end
            PH_CTRL, PH_ACQ: begin
               if (ck_rise && st_ff.rcnt != CTRL_BITS) begin
                  nxt_st.shift = {st_ff.shift[5:0], st_ff.din_s2};
                  nxt_st.rcnt  = st_ff.rcnt + 3'h1;
                  // Word takes effect only when complete, so a cut frame keeps the old one
                  if (st_ff.rcnt + 3'h1 == CTRL_BITS) begin
                     nxt_st.ctrl = {st_ff.shift[5:0], st_ff.din_s2};
                  end
               end
               if (ck_fall) begin
                  nxt_st.fcnt = st_ff.fcnt + 5'h01;
                  nxt_st.dout = 1'b0;
                  if (st_ff.fcnt + 5'h01 == ACQ_START_FALL) begin
                     nxt_st.phase = PH_ACQ;
                     nxt_st.track = 1'b1;
                  end
                  if (st_ff.fcnt + 5'h01 == HOLD_FALL) begin
                     // Hold after three clocks, approximation begins at MSB
                     nxt_st.phase  = PH_CONV;
                     nxt_st.track  = 1'b0;
                     nxt_st.busy   = 1'b1;
                     nxt_st.trial  = MSB_BIT;
                     nxt_st.result = '0;
                     nxt_st.dac    = MSB_BIT;
                     nxt_st.valid  = addr_valid(st_ff.ctrl[6:4], st_ff.ctrl[2]);
                  end
               end
            end
            PH_CONV: begin
               // One approximation step per falling edge of the serial clock
               if (ck_fall) begin
                  nxt_st.busy   = 1'b0;
                  nxt_st.fcnt   = st_ff.fcnt + 5'h01;
                  nxt_st.dout   = st_ff.cmp_s2;
                  nxt_st.result = st_ff.cmp_s2 ? (st_ff.result | st_ff.trial)
                                               : st_ff.result;
                  nxt_st.trial  = st_ff.trial >> 1;
                  nxt_st.dac    = (st_ff.cmp_s2 ? (st_ff.result | st_ff.trial)
                                                : st_ff.result) | (st_ff.trial >> 1);
                  if (st_ff.fcnt + 5'h01 == LAST_FALL) begin
                     nxt_st.phase = PH_IDLE;
                  end
               end
            end
            default: nxt_st.phase = PH_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff        <= '0;
         st_ff.cs_s1  <= 1'b1;
         st_ff.cs_s2  <= 1'b1;
         st_ff.phase  <= PH_IDLE;
         st_ff.fcnt   <= RST_FCNT;
         st_ff.rcnt   <= RST_RCNT;
         st_ff.ctrl   <= RST_CTRL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Pin drivers; data and busy outputs float while deselected
   assign serial_out.dout     = st_ff.dout;
   assign serial_out.dout_oe  = ~st_ff.cs_s2;
   assign serial_out.busy     = st_ff.busy;
   assign serial_out.busy_oe  = ~st_ff.cs_s2;
   assign pen_touch_irq_n     = 1'b0;
   assign pen_touch_irq_n_oe  = st_ff.pen_s2;
   assign track_hold_acquire  = st_ff.track;
   assign sar_code            = st_ff.dac;
   assign conv_ctrl           = st_ff.ctrl;
   assign ctrl_valid          = st_ff.valid;

   property p_dout_float;
      (chip_sel_n ##1 chip_sel_n) |=> !serial_out.dout_oe ##1 !serial_out.dout;
   endproperty
   a_dout_float: assert property (p_dout_float) else $error("data driven while deselected");

   property p_busy_float;
      (chip_sel_n ##1 chip_sel_n) |=> !serial_out.busy_oe ##1 !serial_out.busy;
   endproperty
   a_busy_float: assert property (p_busy_float) else $error("busy driven while deselected");

   property p_din_capture;
      (st_ff.phase == PH_CTRL && !st_ff.cs_s2 && ck_rise && st_ff.rcnt == 3'h0)
         |=> st_ff.shift[0] == $past(st_ff.din_s2) && st_ff.rcnt == 3'h1;
   endproperty
   a_din_capture: assert property (p_din_capture) else $error("control bit not captured");

   property p_start;
      (st_ff.phase == PH_IDLE && !st_ff.cs_s2 && ck_rise && st_ff.din_s2)
         |=> st_ff.phase == PH_CTRL && st_ff.fcnt == 5'h00;
   endproperty
   a_start: assert property (p_start) else $error("start bit not taken");

   property p_acq_start;
      $rose(st_ff.track) |-> st_ff.fcnt == 5'h05 && $past(ck_fall) && st_ff.phase == PH_ACQ;
   endproperty
   a_acq_start: assert property (p_acq_start) else $error("acquisition began on wrong edge");

   property p_acq_len;
      ($fell(st_ff.track) && st_ff.phase == PH_CONV) |-> st_ff.fcnt == 5'h08 && st_ff.busy;
   endproperty
   a_acq_len: assert property (p_acq_len) else $error("acquisition not three clocks");

   property p_dout_update;
      (st_ff.phase == PH_CONV && !st_ff.cs_s2 && ck_fall)
         |=> serial_out.dout == $past(st_ff.cmp_s2) && !st_ff.busy;
   endproperty
   a_dout_update: assert property (p_dout_update) else $error("result bit not shifted");

   property p_msb_first;
      $rose(st_ff.busy) |-> st_ff.trial == MSB_BIT && st_ff.result == '0;
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("conversion not from MSB");

   property p_pen_od;
      ($rose(pen_touched) ##1 pen_touched) |-> ##1 (pen_touch_irq_n_oe && !pen_touch_irq_n);
   endproperty
   a_pen_od: assert property (p_pen_od) else $error("pen interrupt not pulled low");

   property p_abort;
      st_ff.cs_s2 |=> st_ff.phase == PH_IDLE && !st_ff.track && st_ff.fcnt == 5'h00;
   endproperty
   a_abort: assert property (p_abort) else $error("deselect did not abandon word");

   property p_ctrl_whole;
      $changed(st_ff.ctrl) |-> st_ff.rcnt == CTRL_BITS;
   endproperty
   a_ctrl_whole: assert property (p_ctrl_whole) else $error("control word changed early");

   property p_drive_sel;
      (!chip_sel_n ##1 !chip_sel_n) |=> serial_out.dout_oe && serial_out.busy_oe;
   endproperty
   a_drive_sel: assert property (p_drive_sel) else $error("outputs not driven while selected");

endmodule

// ---- design/touch_adc_pkg.sv ----
// Constants, types and decode helpers for the touch converter serial port
// Contract
// - Each result bit updated on falling clock.
// - Data output floats while chip select high.
// - Busy output floats while chip select high.
// - Control bits captured on rising clock edges.
// - Select low starts conversion, enables shifter. Here select low only enables; conversion waits for the start bit.
// - Serial clock paces the approximation steps.
// - Acquisition starts fifth falling edge after start.
// - Acquisition lasts exactly three serial clocks.
// - Pen interrupt is open drain, pulls low.
// - Result shifts MSB first, then zeros.
// - Channel address plus mode bit; others invalid.
package touch_adc_pkg;

   // Control word after the start bit: address, mode, input type, power
   localparam logic [2:0] CTRL_BITS      = 3'h7;
   // Falling-edge counts measured from start-bit detection
   localparam logic [4:0] ACQ_START_FALL = 5'h05;
   localparam logic [4:0] ACQ_CYCLES     = 5'h03;
   localparam logic [4:0] HOLD_FALL      = ACQ_START_FALL + ACQ_CYCLES;
   localparam logic [4:0] RESULT_FALLS   = 5'h0C;
   localparam logic [4:0] LAST_FALL      = HOLD_FALL + RESULT_FALLS;
   // Values after reset
   localparam logic [6:0] RST_CTRL       = 7'h00;
   localparam logic [4:0] RST_FCNT       = 5'h00;
   localparam logic [2:0] RST_RCNT       = 3'h0;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CTRL = 2'b01,
      PH_ACQ  = 2'b11,
      PH_CONV = 2'b10
   } phase_t;

   typedef struct packed {
      logic       channel_addr_bit2;
      logic       channel_addr_bit1;
      logic       channel_addr_bit0;
      logic       mode_8bit;
      logic       single_ended_select;
      logic [1:0] power_mode;
   } conv_ctrl_t;

   typedef struct packed {
      logic dout;
      logic dout_oe;
      logic busy;
      logic busy_oe;
   } serial_out_t;

   // Valid channel addresses for single-ended and differential inputs
   function automatic logic addr_valid(input logic [2:0] addr, input logic single);
      logic ok;
      ok = 1'b0;
      case (addr)
         3'b001, 3'b101, 3'b110: ok = 1'b1;
         3'b010:                 ok = single;
         default:                ok = 1'b0;
      endcase
      return ok;
   endfunction

endpackage

// ---- sim/touch_host_model.sv ----
// Host controller model that frames transfers on the converter's serial link
`timescale 1ns/1ps
module touch_host_model (
   output logic                       chip_sel_n,
   output logic                       serial_conv_clock,
   output logic                       serial_din,
   input  wire touch_adc_pkg::serial_out_t serial_out
);
   import touch_adc_pkg::*;

   // Link idles deselected with its clock standing low
   initial begin
      chip_sel_n        = 1'b1;
      serial_conv_clock = 1'b0;
      serial_din        = 1'b0;
   end

   // Framed transfer of nclk clocks, 125 ns period; din leads each rise by 20 ns,
   // dout is sampled 42.5 ns after each fall, once the device has moved it
   task automatic xfer(input logic [7:0] word, input int nclk,
                       output logic [15:0] got, output logic drove);
      got        = 16'h0000;
      drove      = 1'b1;
      // Step off the system clock edge so no pin moves where the device samples
      #1 chip_sel_n = 1'b0;
      #100;
      for (int i = 0; i < nclk; i++) begin
         serial_din = (i < 8) ? word[7-i] : 1'b0;
         #20 serial_conv_clock = 1'b1;
         #62.5 serial_conv_clock = 1'b0;
         // A released output reads as the inverse of its level, so a float is caught
         #42.5 got = {got[14:0], serial_out.dout_oe ? serial_out.dout : ~serial_out.dout};
         drove = drove & serial_out.dout_oe & serial_out.busy_oe;
      end
      #100 chip_sel_n = 1'b1;
      serial_din = ~serial_din;
      #300;
   endtask

   // Clock and start-like data while deselected, which the device must ignore
   task automatic noise(input int n);
      serial_din = 1'b1;
      for (int i = 0; i < n; i++) begin
         #62.5 serial_conv_clock = 1'b1;
         #62.5 serial_conv_clock = 1'b0;
      end
      serial_din = 1'b0;
   endtask
endmodule

// ---- sim/touch_adc_serial_port_tb.sv ----
// Self-checking bench for the touch converter serial port
`timescale 1ns/1ps
module touch_adc_serial_port_tb;
   import touch_adc_pkg::*;

   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        pen_touched = 1'b0;
   logic        chip_sel_n;
   logic        serial_conv_clock;
   logic        serial_din;
   logic [11:0] target = 12'h000;
   serial_out_t serial_out;
   conv_ctrl_t  conv_ctrl;
   logic        pen_touch_irq_n;
   logic        pen_touch_irq_n_oe;
   logic        track_hold_acquire;
   logic [11:0] sar_code;
   logic        ctrl_valid;
   int          num_errors = 0;
   int          n_compared = 0;
   int          fall_n = 0;
   int          track_at = 0;
   int          busy_at = 0;
   int          track_cnt = 0;
   int          track_len = 0;
   // Comparator of the analog side: high while the input is at or above the trial code
   wire         cmp_above = (target >= sar_code);
   // Pen interrupt pin with its external pull-up
   wire         pen_pin = pen_touch_irq_n_oe ? pen_touch_irq_n : 1'b1;

   always #5 clk = ~clk;

   touch_adc_serial_port uut (.clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
      .serial_conv_clock(serial_conv_clock), .serial_din(serial_din), .cmp_above(cmp_above),
      .pen_touched(pen_touched), .serial_out(serial_out), .pen_touch_irq_n(pen_touch_irq_n),
      .pen_touch_irq_n_oe(pen_touch_irq_n_oe), .track_hold_acquire(track_hold_acquire),
      .sar_code(sar_code), .conv_ctrl(conv_ctrl), .ctrl_valid(ctrl_valid));

   touch_host_model host (.chip_sel_n(chip_sel_n), .serial_conv_clock(serial_conv_clock),
      .serial_din(serial_din), .serial_out(serial_out));

   // Falling edges in the frame at which acquisition and busy begin, and window length
   always @(negedge chip_sel_n) fall_n = 0;
   always @(negedge serial_conv_clock) fall_n++;
   always @(posedge track_hold_acquire) track_at = fall_n;
   always @(posedge serial_out.busy) busy_at = fall_n;
   always @(posedge clk) begin
      track_cnt <= track_hold_acquire ? track_cnt + 1 : 0;
      if (!track_hold_acquire && track_cnt != 0)
         track_len <= track_cnt;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic t_reset;
      check("outputs after reset", 16'h0000, {11'h000, serial_out.dout_oe,
            serial_out.busy_oe, pen_touch_irq_n_oe, track_hold_acquire, ctrl_valid});
   endtask

   // Every channel address in both input modes, results from zero to full scale
   task automatic t_convert;
      logic [15:0] got;
      logic        drove;
      logic        ok;
      for (int k = 0; k < 16; k++) begin
         @(posedge clk);
         target <= (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : 12'h0A5 * 12'(k);
         ok = (k[2:0] == 3'h1) || (k[2:0] == 3'h5) || (k[2:0] == 3'h6) || (k[2:0] == 3'h2 && k[3]);
         host.xfer({1'b1, 3'(k), 1'b0, k[3], 2'b11}, 24, got, drove);
         check("result", {target, 4'h0}, got);
         check("driven", 16'h0001, {15'h0000, drove});
         check("control", {9'h000, 3'(k), 1'b0, k[3], 2'b11}, {9'h000, conv_ctrl});
         check("valid", {15'h0000, ok}, {15'h0000, ctrl_valid});
         check("acquire edge", 16'h0005, 16'(track_at));
         check("busy edge", 16'h0008, 16'(busy_at));
         check("acquire len ok", 16'h0001, {15'h0000, track_len inside {37, 38}});
         check("released", 16'h0000, {14'h0000, serial_out.dout_oe, serial_out.busy_oe});
      end
   endtask

   // Deselect in mid-word, clock while deselected, then a clean conversion
   task automatic t_abort;
      logic [15:0] got;
      logic        drove;
      host.xfer(8'hD7, 4, got, drove);
      host.noise(10);
      check("ctrl kept", 16'h0077, {9'h000, conv_ctrl});
      check("floating", 16'h0000, {14'h0000, serial_out.dout_oe, serial_out.busy_oe});
      @(posedge clk);
      target <= 12'h5A3;
      host.xfer(8'h94, 24, got, drove);
      check("result after abort", 16'h5A30, got);
      check("driven after abort", 16'h0001, {15'h0000, drove});
      check("control after abort", 16'h0014, {9'h000, conv_ctrl});
   endtask

   task automatic t_pen;
      int n;
      @(posedge clk);
      pen_touched <= 1'b1;
      n = 0;
      while (pen_touch_irq_n_oe !== 1'b1 && n < 10) begin
         @(posedge clk);
         n++;
      end
      check("pen pulls", 16'h0001, {15'h0000, pen_touch_irq_n_oe});
      check("pen level", 16'h0000, {15'h0000, pen_pin});
      pen_touched <= 1'b0;
      repeat (4) @(posedge clk);
      check("pen released", 16'h0000, {15'h0000, pen_touch_irq_n_oe});
      check("pen pin idle", 16'h0001, {15'h0000, pen_pin});
   endtask

   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset;
      t_convert;
      t_abort;
      t_pen;
      test_done;
   end

   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      test_done;
   end
endmodule
